// ---- core/fkl_linearizer.sv ----
// Top of the flow divider linearizer: frequency gate, point table and totaliser.
// How it works
// - Table holds two to sixteen frequency points.
// - Point divider limited to 0.000122 through 999999.
// - Slope taken from two nearest stored points.
// - Divider interpolated along slope, fixed-point arithmetic.
// - Divider applies to pulses until next measurement.
// - Zero first frequency: first divider before measurement.
// - Zero divider entry is stored as one.
// - Below first frequency outside test mode: no rate, no count.
// - Zero frequency at point three up ends table.
// - Extrapolated divider is forced positive.
// - Rate decimal shifts with decimal position setting outside test mode.
// - Test mode uses divider one everywhere.
// - Confirm on point zero in test enters run.
`timescale 1ns/1ps
`include "fkl_consts.svh"

module fkl_linearizer
  import fkl_pkg::*;
#(
  parameter int GATE_CYCLES = `FKL_GATE_CYC,
  parameter int NPTS        = `FKL_PTS
)
(
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        PULSE_IN,
  input  wire logic        POINT_WE,
  input  wire logic [3:0]  POINT_IDX,
  input  wire fkl_freq_t   POINT_FREQ,
  input  wire fkl_div_t    POINT_DIV,
  input  wire logic        TEST_MODE,
  input  wire logic        CONFIRM_KEY,
  input  wire logic [3:0]  MENU_POINT,
  input  wire logic        SETUP_REQ,
  input  wire logic [2:0]  DECIMAL_POSITION_SETTING,
  input  wire logic        TOTAL_CLR,
  output logic             RUN_MODE,
  output logic             CUTOFF,
  output logic             RATE_VALID,
  output fkl_freq_t        FREQ,
  output fkl_div_t         DIVIDER,
  output logic [31:0]      RATE,
  output logic [31:0]      TOTAL,
  output logic [2:0]       RATE_DP_SHIFT
);

  // ******************************************************************
  // Declarations.
  // ******************************************************************
  logic [2:0]  sync_q;        // Three-stage pin synchroniser.
  logic        lvl_q;         // Debounced input level.
  logic        rise;          // One-cycle pulse per rising input edge.
  logic [31:0] gate_q;        // Gate timer.
  fkl_freq_t   pcnt_q;        // Pulses seen in the running gate.
  logic        gate_end;      // Last cycle of a gate.
  fkl_freq_t   freq_q [NPTS]; // Point frequencies.
  fkl_div_t    kdiv_q [NPTS]; // Point dividers.
  logic        meas_q;        // At least one gate has completed.
  fkl_state_e  st_q;          // Recalculation sequencer.
  logic        neg_q;         // Slope descends between the two points.
  logic [36:0] acc_q;         // Fractional pulse accumulator.
  logic        apply;         // Pulse is counted.
  logic [4:0]  n_act;         // Points in use.
  logic [3:0]  seg;           // Lower point of the chosen segment.
  logic [37:0] interp;        // Signed interpolated divider.
  fkl_div_t    step;          // Proportional step, saturated.

  fkl_div_if #(.W(64)) dv ();

  fkl_divider #(.W(64)) u_div (
    .clk   (CLK),
    .rst_n (RST_N),
    .dv    (dv.solver)
  );

  // Entry limits: zero becomes one, otherwise held inside the range.
  function automatic fkl_div_t fkl_clamp(input logic [37:0] v, input logic zero_one);
    if (zero_one && v == 38'h0)
      return `FKL_DIV_ONE;
    else if (v[37] || v < 38'(`FKL_DIV_MIN))
      return `FKL_DIV_MIN;
    else if (v > 38'(`FKL_DIV_MAX))
      return `FKL_DIV_MAX;
    else
      return v[35:0];
  endfunction

  // ******************************************************************
  // Pin synchroniser: an edge counts once stages two and three agree.
  // ******************************************************************
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      sync_q <= 3'h0;
      lvl_q  <= 1'b0;
    end
    else
    begin
      sync_q <= {sync_q[1:0], PULSE_IN};
      if (sync_q[1] == sync_q[2])
        lvl_q <= sync_q[2];
    end
  end

  assign rise = (sync_q[1] == sync_q[2]) && sync_q[2] && !lvl_q;

  // ******************************************************************
  // Frequency gate of about one second.
  // ******************************************************************
  assign gate_end = (gate_q == 32'(GATE_CYCLES - 1));

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      gate_q <= 32'h0;
      pcnt_q <= '0;
      FREQ   <= '0;
      meas_q <= 1'b0;
    end
    else if (gate_end)
    begin
      gate_q <= 32'h0;
      pcnt_q <= rise ? `FKL_FREQ_W'(1) : '0;
      FREQ   <= pcnt_q;
      meas_q <= 1'b1;
    end
    else
    begin
      gate_q <= gate_q + 32'h1;
      if (rise && pcnt_q != '1)
        pcnt_q <= pcnt_q + `FKL_FREQ_W'(1);
    end
  end

  // ******************************************************************
  // Point table. Entries are stored limited; ordering is the host's job.
  // ******************************************************************
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      for (int i = 0; i < NPTS; i++)
      begin
        freq_q[i] <= '0;
        kdiv_q[i] <= `FKL_DIV_RST;
      end
    end
    else if (POINT_WE)
    begin
      freq_q[POINT_IDX] <= POINT_FREQ;
      kdiv_q[POINT_IDX] <= fkl_clamp({2'b00, POINT_DIV}, 1'b1);
    end
  end

  // ******************************************************************
  // Segment choice: the table ends at the first zero frequency from
  // point three up; beyond the last pair the slope is extended.
  // ******************************************************************
  always_comb
  begin
    n_act = 5'(NPTS);
    seg   = 4'h0;
    for (int k = NPTS - 1; k >= 2; k--)
      if (freq_q[k] == '0)
        n_act = 5'(k);
    for (int k = 1; k < NPTS - 1; k++)
      if (5'(k + 1) < n_act && FREQ >= freq_q[k])
        seg = 4'(k);
  end

  // Divider from base point plus signed proportional step. A far
  // extrapolation saturates the step, so it clamps instead of wrapping.
  assign step   = (dv.quot[63:36] != 28'h0) ? 36'hF_FFFF_FFFF : dv.quot[35:0];
  assign interp = neg_q ? ({2'b00, kdiv_q[seg]} - {2'b00, step})
                        : ({2'b00, kdiv_q[seg]} + {2'b00, step});

  // ******************************************************************
  // Recalculation sequencer, one pass per gate.
  // ******************************************************************
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      st_q       <= ST_IDLE;
      neg_q      <= 1'b0;
      dv.start   <= 1'b0;
      dv.num     <= '0;
      dv.den     <= '0;
      DIVIDER    <= `FKL_DIV_RST;
      RATE       <= 32'h0;
      RATE_VALID <= 1'b0;
      CUTOFF     <= 1'b1;
    end
    else
    begin
      dv.start <= 1'b0;
      case (st_q)
        ST_IDLE:
        begin
          // Before any gate, a zero first point enables its divider.
          if (!meas_q)
          begin
            CUTOFF  <= (freq_q[0] != '0);
            DIVIDER <= TEST_MODE ? `FKL_DIV_ONE : kdiv_q[0];
          end
          if (gate_end)
            st_q <= ST_SEG;
        end
        ST_SEG:
        begin
          if (TEST_MODE)
          begin
            CUTOFF   <= 1'b0;
            DIVIDER  <= `FKL_DIV_ONE;
            dv.num   <= 64'(FREQ) << `FKL_FRAC;
            dv.den   <= 64'(`FKL_DIV_ONE);
            dv.start <= 1'b1;
            st_q     <= ST_RATE;
          end
          else if (FREQ < freq_q[0])
          begin
            CUTOFF     <= 1'b1;
            RATE       <= 32'h0;
            RATE_VALID <= 1'b0;
            st_q       <= ST_IDLE;
          end
          else
          begin
            // A flat pair gives a zero divisor; the base point divider is then used.
            CUTOFF   <= 1'b0;
            neg_q    <= kdiv_q[seg + 4'h1] < kdiv_q[seg];
            dv.num   <= (kdiv_q[seg + 4'h1] < kdiv_q[seg] ?
                         64'(kdiv_q[seg] - kdiv_q[seg + 4'h1]) :
                         64'(kdiv_q[seg + 4'h1] - kdiv_q[seg])) *
                        64'(FREQ - freq_q[seg]);
            dv.den   <= (freq_q[seg + 4'h1] > freq_q[seg]) ?
                        64'(freq_q[seg + 4'h1] - freq_q[seg]) : 64'h0;
            dv.start <= 1'b1;
            st_q     <= ST_SLOPE;
          end
        end
        ST_SLOPE:
        begin
          if (dv.done)
          begin
            if (dv.den == 64'h0)
              DIVIDER <= kdiv_q[seg];
            else
              DIVIDER <= fkl_clamp(interp, 1'b0);
            dv.num   <= 64'(FREQ) << `FKL_FRAC;
            dv.den   <= (dv.den == 64'h0) ? 64'(kdiv_q[seg]) :
                        64'(fkl_clamp(interp, 1'b0));
            dv.start <= 1'b1;
            st_q     <= ST_RATE;
          end
        end
        ST_RATE:
        begin
          // Rate in display units: pulses per second over the divider.
          if (dv.done)
          begin
            RATE       <= dv.quot[31:0];
            RATE_VALID <= 1'b1;
            st_q       <= ST_IDLE;
          end
        end
        default:
          st_q <= ST_IDLE;
      endcase
    end
  end

  // ******************************************************************
  // Setup and run mode, and rate decimal alignment.
  // ******************************************************************
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      RUN_MODE      <= 1'b0;
      RATE_DP_SHIFT <= 3'h0;
    end
    else
    begin
      if (SETUP_REQ)
        RUN_MODE <= 1'b0;
      else if (TEST_MODE && CONFIRM_KEY && MENU_POINT == 4'h0)
        RUN_MODE <= 1'b1;
      RATE_DP_SHIFT <= TEST_MODE ? 3'h0 : DECIMAL_POSITION_SETTING;
    end
  end

  // ******************************************************************
  // Totaliser: each pulse adds one in divider units; one count is taken
  // per cycle while the accumulator holds a whole divider. Pulses far
  // below the clock rate are assumed when the divider is below one.
  // ******************************************************************
  assign apply = rise && RUN_MODE && !CUTOFF;

  always_ff @(posedge CLK)
  begin
    if (!RST_N || TOTAL_CLR)
    begin
      acc_q <= 37'h0;
      TOTAL <= 32'h0;
    end
    else
    begin
      acc_q <= acc_q + (apply ? 37'(`FKL_DIV_ONE) : 37'h0)
                     - ((acc_q >= {1'b0, DIVIDER}) ? {1'b0, DIVIDER} : 37'h0);
      if (acc_q >= {1'b0, DIVIDER})
        TOTAL <= TOTAL + 32'h1;
    end
  end

endmodule

// ---- inc/fkl_consts.svh ----
// Constant definitions for the flow divider linearizer.
`ifndef FKL_CONSTS_SVH
`define FKL_CONSTS_SVH

// ********************************************************************
// Fixed-point layout of a divider factor (unsigned, 20.16).
// ********************************************************************
`define FKL_DIV_W     36
`define FKL_FRAC      16
`define FKL_FREQ_W    24
`define FKL_PTS       16
`define FKL_DIV_ONE   36'h0_0001_0000
`define FKL_DIV_MIN   36'h0_0000_0008
`define FKL_DIV_MAX   36'hF_423F_0000
`define FKL_DIV_RST   36'h0_0001_0000

// ********************************************************************
// Timing: gate of one second at a 5 ns clock.
// ********************************************************************
`define FKL_CLK_NS    5
`define FKL_GATE_NS   1000000000
`define FKL_GATE_CYC  (`FKL_GATE_NS / `FKL_CLK_NS)

`endif

// ---- inc/fkl_pkg.sv ----
// Types shared by the flow divider linearizer modules.
`include "fkl_consts.svh"

package fkl_pkg;

  typedef logic [`FKL_DIV_W-1:0]  fkl_div_t;   // Divider factor, 20.16 fixed point.
  typedef logic [`FKL_FREQ_W-1:0] fkl_freq_t;  // Frequency in pulses per gate.

  // Sequencer states of the per-second recalculation.
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_SEG   = 4'b0010,
    ST_SLOPE = 4'b0100,
    ST_RATE  = 4'b1000
  } fkl_state_e;

endpackage

// ---- inc/fkl_div_if.sv ----
// Request and answer wires between the sequencer and the serial divider.
`timescale 1ns/1ps

interface fkl_div_if #(parameter int W = 64);
  logic         start;  // One-cycle request pulse.
  logic [W-1:0] num;    // Dividend, held while busy.
  logic [W-1:0] den;    // Divisor, held while busy.
  logic         done;   // One-cycle pulse, quotient valid.
  logic [W-1:0] quot;   // Quotient, stands until next start.

  modport requester (output start, output num, output den, input done, input quot);
  modport solver    (input start, input num, input den, output done, output quot);
endinterface

// ---- core/fkl_divider.sv ----
// Serial restoring divider, one quotient bit per clock.
`timescale 1ns/1ps

module fkl_divider
  import fkl_pkg::*;
#(
  parameter int W = 64
)
(
  input wire logic   clk,
  input wire logic   rst_n,
  fkl_div_if.solver  dv
);

  logic [W:0]   rem_q;  // Partial remainder.
  logic [W-1:0] quo_q;  // Dividend shifting out, quotient shifting in.
  logic [6:0]   cnt_q;  // Bits still to produce.
  logic         done_q; // Completion pulse.
  logic [W:0]   trial;  // Remainder after the next shift.

  assign trial   = {rem_q[W-1:0], quo_q[W-1]};
  assign dv.quot = quo_q;
  assign dv.done = done_q;

  // ******************************************************************
  // Shift and subtract. A zero divisor yields all ones, so the caller
  // must guard it; it never hangs.
  // ******************************************************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rem_q  <= '0;
      quo_q  <= '0;
      cnt_q  <= 7'h00;
      done_q <= 1'b0;
    end
    else if (dv.start)
    begin
      rem_q  <= '0;
      quo_q  <= dv.num;
      cnt_q  <= 7'(W);
      done_q <= 1'b0;
    end
    else if (cnt_q != 7'h00)
    begin
      if (trial >= {1'b0, dv.den})
      begin
        rem_q <= trial - {1'b0, dv.den};
        quo_q <= {quo_q[W-2:0], 1'b1};
      end
      else
      begin
        rem_q <= trial;
        quo_q <= {quo_q[W-2:0], 1'b0};
      end
      cnt_q  <= cnt_q - 7'h01;
      done_q <= (cnt_q == 7'h01);
    end
    else
    begin
      done_q <= 1'b0;
    end
  end

endmodule

// ---- testbench/fkl_pulse_src.sv ----
// Flow sensor model that sends pulse bursts.
`timescale 1ns/1ps

module fkl_pulse_src
(
  input  wire logic        clk,
  input  wire logic        en,
  input  wire logic [7:0]  half,
  input  wire logic [15:0] limit,
  output logic             pulse = 1'b0,
  output logic [15:0]      sent = 16'h0000
);
  // ****
  // Pulse generator
  // ****
  logic [7:0] ph_q = 8'h00; // Cycles spent at the present level.

  // Each level lasts half cycles, so the pin never moves faster than the
  // input filter allows. A burst always ends low, like a pulled-down output.
  always @(negedge clk)
  begin
    if (!en)
    begin
      pulse <= 1'b0;
      ph_q  <= 8'h00;
      sent  <= 16'h0000;
    end
    else if (ph_q + 8'h01 < half)
      ph_q <= ph_q + 8'h01;
    else if (pulse || sent < limit)
    begin
      ph_q  <= 8'h00;
      pulse <= !pulse;
      sent  <= sent + {15'h0000, !pulse};
    end
  end
endmodule

// ---- testbench/fkl_linearizer_assertions.sv ----
// Port checks of the flow divider linearizer.
`timescale 1ns/1ps
`include "fkl_consts.svh"

module fkl_linearizer_assertions
  import fkl_pkg::*;
#(
  parameter int GATE_CYCLES = `FKL_GATE_CYC
)
(
  input wire logic        CLK,
  input wire logic        RST_N,
  input wire logic        TEST_MODE,
  input wire logic        CONFIRM_KEY,
  input wire logic [3:0]  MENU_POINT,
  input wire logic        SETUP_REQ,
  input wire logic [2:0]  DECIMAL_POSITION_SETTING,
  input wire logic        RUN_MODE,
  input wire logic        CUTOFF,
  input wire logic        RATE_VALID,
  input wire fkl_freq_t   FREQ,
  input wire fkl_div_t    DIVIDER,
  input wire logic [31:0] RATE,
  input wire logic [31:0] TOTAL,
  input wire logic [2:0]  RATE_DP_SHIFT
);
  // ****
  // Gate spacing helper
  // ****
  int        since_q; // Cycles since FREQ last moved.
  logic      seen_q;  // A first update was seen.
  fkl_freq_t freq_q;  // FREQ one cycle back.

  // The first update has an unknown phase, so only later ones are timed.
  always_ff @(posedge CLK)
  begin
    freq_q <= FREQ;
    if (!RST_N)
    begin
      since_q <= 0;
      seen_q  <= 1'b0;
    end
    else if (FREQ != freq_q)
    begin
      since_q <= 0;
      seen_q  <= 1'b1;
    end
    else
      since_q <= since_q + 1;
  end

  // ****
  // Properties
  // ****
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  // Confirm on the first menu point while testing.
  sequence confirm_s;
    CONFIRM_KEY && TEST_MODE && MENU_POINT == 4'h0 && !SETUP_REQ;
  endsequence

  // Both settings calm for two cycles.
  sequence calm_s;
    ($stable(TEST_MODE) && $stable(DECIMAL_POSITION_SETTING)) [*2];
  endsequence

  run_entry_a: assert property (confirm_s |=> RUN_MODE)
    else $error("run not entered");
  setup_exit_a: assert property (SETUP_REQ |=> !RUN_MODE)
    else $error("setup left run on");
  div_range_a: assert property (DIVIDER >= `FKL_DIV_MIN && DIVIDER <= `FKL_DIV_MAX)
    else $error("divider out of range");
  test_div_a: assert property (TEST_MODE && $past(TEST_MODE) && $changed(DIVIDER) |-> DIVIDER == `FKL_DIV_ONE)
    else $error("test divider not one");
  test_rate_a: assert property (RATE_VALID && $changed(RATE) && DIVIDER == `FKL_DIV_ONE |-> RATE == {8'h00, FREQ})
    else $error("unit rate wrong");
  cut_rate_a: assert property (CUTOFF |-> !RATE_VALID && RATE == 32'h0)
    else $error("rate shown below cutoff");
  dp_shift_a: assert property (calm_s |-> RATE_DP_SHIFT == (TEST_MODE ? 3'h0 : DECIMAL_POSITION_SETTING))
    else $error("decimal shift wrong");
  gate_period_a: assert property (seen_q && FREQ != freq_q |-> since_q % GATE_CYCLES == GATE_CYCLES - 1)
    else $error("gate period wrong");
  total_step_a: assert property ($changed(TOTAL) && TOTAL != 32'h0 |-> TOTAL == $past(TOTAL) + 32'h1)
    else $error("total jumped");
endmodule

bind fkl_linearizer fkl_linearizer_assertions #(.GATE_CYCLES(GATE_CYCLES)) u_chk (
  .CLK, .RST_N, .TEST_MODE, .CONFIRM_KEY, .MENU_POINT, .SETUP_REQ,
  .DECIMAL_POSITION_SETTING, .RUN_MODE, .CUTOFF, .RATE_VALID, .FREQ,
  .DIVIDER, .RATE, .TOTAL, .RATE_DP_SHIFT
);

// ---- testbench/fkl_linearizer_tb.sv ----
// Self-checking bench of the flow divider linearizer.
`timescale 1ns/1ps
`include "fkl_consts.svh"

module fkl_linearizer_tb
  import fkl_pkg::*;
();
  localparam int G = 240; // Short gate; pulse periods divide it evenly.

  logic        clk = 1'b0;   // System clock.
  logic        rst_n = 1'b0; // Reset, active low.
  logic        pulse;        // Sensor pin.
  logic        we = 1'b0;    // Point write strobe.
  logic [3:0]  idx = 4'h0;   // Point index.
  fkl_freq_t   pf = '0;      // Point frequency.
  fkl_div_t    pd = '0;      // Point divider.
  logic        test = 1'b0;  // Test mode.
  logic        conf = 1'b0;  // Confirm key.
  logic [3:0]  menu = 4'h0;  // Menu point.
  logic        setup = 1'b0; // Back to setup.
  logic [2:0]  dps = 3'h0;   // Dummy decimals.
  logic        clr = 1'b0;   // Total clear.
  logic        en = 1'b0;    // Sensor on.
  logic [7:0]  half = 8'h04; // Sensor half period.
  logic [15:0] lim = 16'h0;  // Burst length.
  logic        run;          // Run mode.
  logic        cut;          // Cutoff flag.
  logic        rv;           // Rate valid.
  fkl_freq_t   freq;         // Measured frequency.
  fkl_div_t    div;          // Divider in use.
  logic [31:0] rate;         // Rate.
  logic [31:0] total;        // Total.
  logic [2:0]  dpsh;         // Rate decimal shift.
  int          fail_count = 0;
  int          check_count = 0;

  // ****
  // Harness
  // ****
  fkl_linearizer #(.GATE_CYCLES(G)) uut (
    .CLK(clk), .RST_N(rst_n), .PULSE_IN(pulse), .POINT_WE(we), .POINT_IDX(idx),
    .POINT_FREQ(pf), .POINT_DIV(pd), .TEST_MODE(test), .CONFIRM_KEY(conf),
    .MENU_POINT(menu), .SETUP_REQ(setup), .DECIMAL_POSITION_SETTING(dps),
    .TOTAL_CLR(clr), .RUN_MODE(run), .CUTOFF(cut), .RATE_VALID(rv), .FREQ(freq),
    .DIVIDER(div), .RATE(rate), .TOTAL(total), .RATE_DP_SHIFT(dpsh)
  );

  fkl_pulse_src u_src (.clk(clk), .en(en), .half(half), .limit(lim), .pulse(pulse), .sent());

  // Clock of 5 ns period.
  always #2.5 clk = ~clk;

  // Compares one value; an unknown never matches.
  task automatic check(input logic [35:0] got, input logic [35:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Writes one point table entry.
  task automatic wr(input logic [3:0] i, input fkl_freq_t f, input fkl_div_t d);
    @(negedge clk);
    we  = 1'b1;
    idx = i;
    pf  = f;
    pd  = d;
    @(negedge clk);
    we = 1'b0;
  endtask

  // Presses confirm on menu point m.
  task automatic press(input logic [3:0] m);
    @(negedge clk);
    menu = m;
    conf = 1'b1;
    @(negedge clk);
    conf = 1'b0;
  endtask

  // Lets the sensor finish low, then starts n pulses at half period h.
  task automatic flow(input logic [7:0] h, input logic [15:0] n);
    @(negedge clk);
    lim = 16'h0;
    repeat (64) @(negedge clk);
    en = 1'b0;
    @(negedge clk);
    half = h;
    lim  = n;
    en   = 1'b1;
  endtask

  // Mode entry, unit divider and exact pulse totals.
  task automatic t_test();
    test = 1'b1;
    dps  = 3'h3;
    press(4'h1);
    check(run, 1'b0);
    press(4'h0);
    check(run, 1'b1);
    flow(8'h04, 16'hFFFF);
    repeat (3 * G) @(negedge clk);
    check(div, `FKL_DIV_ONE);
    check(rate, 32'h1E);
    check(rv, 1'b1);
    check(dpsh, 3'h0);
    flow(8'h04, 16'h0);
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    flow(8'h04, 16'h25);
    repeat (340) @(negedge clk);
    check(total, 32'h25);
    setup = 1'b1;
    @(negedge clk);
    setup = 1'b0;
    check(run, 1'b0);
    flow(8'h04, 16'h0A);
    repeat (200) @(negedge clk);
    check(total, 32'h25);
    press(4'h0);
    test = 1'b0;
  endtask

  // Interpolation, table end and a zero divider entry.
  task automatic t_line();
    logic [7:0] hs [5] = '{8'h18, 8'h0C, 8'h08, 8'h04, 8'h03};
    fkl_freq_t  fs [5] = '{24'h5, 24'hA, 24'hF, 24'h1E, 24'h28};
    fkl_div_t   ds [5] = '{36'h5_8000, 36'hA_0000, 36'hF_8000, 36'h28_0000, 36'h3B_0000};
    wr(4'h0, 24'h0, 36'h0);
    wr(4'h1, 24'hA, 36'hA_0000);
    wr(4'h2, 24'h14, 36'h15_0000);
    wr(4'h3, 24'h1E, 36'h28_0000);
    wr(4'h4, 24'h0, 36'h1_0000);
    wr(4'h5, 24'h64, 36'h1_0000);
    foreach (hs[i])
    begin
      flow(hs[i], 16'hFFFF);
      repeat (3 * G) @(negedge clk);
      check(freq, fs[i]);
      check(div, ds[i]);
    end
    check(dpsh, 3'h3);
  endtask

  // Clamping, a falling slope and the low cutoff.
  task automatic t_clamp();
    wr(4'h3, 24'h1E, 36'h1_0000);
    repeat (3 * G) @(negedge clk);
    check(div, `FKL_DIV_MIN);
    wr(4'h1, 24'hA, 36'hF_FFFF_FFFF);
    flow(8'h0C, 16'hFFFF);
    repeat (3 * G) @(negedge clk);
    check(div, `FKL_DIV_MAX);
    // A unit divider in use makes any leak past the cutoff show in the total.
    wr(4'h1, 24'hA, 36'h1_0000);
    repeat (3 * G) @(negedge clk);
    check(div, `FKL_DIV_ONE);
    wr(4'h0, 24'h5, 36'h1_0000);
    flow(8'h1E, 16'hFFFF);
    repeat (3 * G) @(negedge clk);
    check(cut, 1'b1);
    check(rv, 1'b0);
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    repeat (G) @(negedge clk);
    check(total, 32'h0);
  endtask

  // Main sequence.
  initial
  begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    check(div, `FKL_DIV_ONE);
    check(run, 1'b0);
    repeat (2) @(negedge clk);
    check(cut, 1'b0);
    check(total, 32'h0);
    t_test();
    t_line();
    t_clamp();
    report_and_stop();
  end
endmodule
